// ===== core/capture_sync.sv
`timescale 1ns/1ps
module capture_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge i_clk) begin
    meta <= i_async;
    o_sync <= meta;
  end
endmodule

// ===== core/ddr3_capture_qualifier.sv
`timescale 1ns/1ps
`include "capture_qualifier_regs.svh"
// How it works
// R1: rank setting selects active chip selects
// R2: write data placed write latency after command
// R3: only five rank/latency combinations accepted
// R4: reset gives single rank, latency five
// R5: cke mode drops samples when both low
// R6: unqualified mode stores every clock edge
// R7: two-card variant qualifies only single rank
// R8: fixed burst of eight or four
// R9: dynamic mode reads burst-chop at command
// R10: control strobes are active low
// R11: unqualified cycle writes nothing, pointer holds
module ddr3_capture_qualifier
  import capture_qualifier_pkg::*;
#(
  parameter int DATA_W = 72,
  parameter int ADDR_W = 12
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_rank_cfg,
  input wire logic i_cke_mode,
  input wire logic i_two_card,
  input wire logic [1:0] i_burst_cfg,
  input wire logic i_bus_clk,
  input wire logic [3:0] i_cs_b,
  input wire logic [1:0] i_cke,
  input wire logic i_ras_b,
  input wire logic i_cas_b,
  input wire logic i_we_b,
  input wire logic i_bc_b,
  input wire logic [DATA_W-1:0] i_dq,
  output logic o_mem_we,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [DATA_W+1:0] o_mem_data,
  output logic [2:0] o_rank_active,
  output logic [3:0] o_write_latency,
  output logic o_cfg_error,
  output logic [ADDR_W-1:0] o_stored_count
);
  // configuration in the reference domain
  rank_cfg_t rank_cfg;
  rank_cfg_t next_rank_cfg;
  logic cfg_error;
  logic next_cfg_error;
  logic [3:0] wl;
  logic [3:0] next_wl;
  logic [3:0] cs_mask;
  logic [3:0] next_cs_mask;
  logic cke_qual;
  logic next_cke_qual;
  burst_cfg_t burst_cfg;
  burst_cfg_t next_burst_cfg;

  always_comb begin
    next_rank_cfg = rank_cfg;
    next_cfg_error = 1'b0;
    unique case (i_rank_cfg)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: next_rank_cfg = rank_cfg_t'(i_rank_cfg); // see R3
      default: next_cfg_error = 1'b1; // see R3
    endcase
    if (!i_rst_b) begin
      next_rank_cfg = single_rank_setting; // see R4
      next_cfg_error = 1'b0;
    end
    unique case (next_rank_cfg)
      single_rank_setting: begin
        next_cs_mask = 4'h1; // see R1
        next_wl = `LATENCY_FIVE; // see R2
      end
      dual_rank_setting: begin
        next_cs_mask = 4'h3; // see R1
        next_wl = `LATENCY_FIVE;
      end
      quad_rank_setting: begin
        next_cs_mask = 4'hf; // see R1
        next_wl = `LATENCY_FIVE;
      end
      single_rank_wl6: begin
        next_cs_mask = 4'h1;
        next_wl = `LATENCY_SIX; // see R2
      end
      quad_rank_write_latency_twelve: begin
        next_cs_mask = 4'hf;
        next_wl = `LATENCY_TWELVE; // see R2
      end
      default: begin
        next_cs_mask = 4'h1;
        next_wl = `LATENCY_FIVE;
      end
    endcase
    // two-card variant: cke qualification only with single rank
    next_cke_qual = i_cke_mode && (!i_two_card || next_cs_mask == 4'h1); // see R7
    next_burst_cfg = (i_burst_cfg == 2'h1) ? burst_of_four :
                     (i_burst_cfg == 2'h2 && !i_two_card) ? burst_dynamic : burst_of_eight; // see R8
    if (!i_rst_b) begin
      next_cke_qual = 1'b1;
      next_burst_cfg = burst_of_eight;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    rank_cfg <= next_rank_cfg;
    cfg_error <= next_cfg_error;
    wl <= next_wl;
    cs_mask <= next_cs_mask;
    cke_qual <= next_cke_qual;
    burst_cfg <= next_burst_cfg;
  end

  // configuration crosses into the bus domain as slow levels
  logic [3:0] b_cs_mask;
  logic [3:0] b_wl;
  logic b_cke_qual;
  logic [1:0] b_burst;
  logic b_rst_b;
  logic [10:0] cfg_raw;
  logic [10:0] cfg_last;
  logic [10:0] cfg_live;
  logic [10:0] next_cfg_live;
  capture_sync #(.WIDTH(1)) u_rst_sync (
    .i_clk(i_bus_clk),
    .i_async(i_rst_b),
    .o_sync(b_rst_b)
  );
  capture_sync #(.WIDTH(11)) u_cfg_sync (
    .i_clk(i_bus_clk),
    .i_async({cs_mask, wl, cke_qual, burst_cfg}),
    .o_sync(cfg_raw)
  );

  // bits of one change may land a cycle apart: take the word once two samples agree
  always_comb begin
    next_cfg_live = cfg_live;
    if (cfg_raw == cfg_last) begin
      next_cfg_live = cfg_raw;
    end
  end

  always_ff @(posedge i_bus_clk) begin
    cfg_last <= cfg_raw;
    cfg_live <= next_cfg_live;
  end

  assign {b_cs_mask, b_wl, b_cke_qual, b_burst} = cfg_live;

  a_cfg_filter: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R1
    cfg_raw != cfg_last |=> cfg_live == $past(cfg_live))
    else $error("unsettled configuration applied");

  // bus-domain qualifier: runs on the memory bus clock zero
  logic [15:0] wr_pipe;
  logic [15:0] next_wr_pipe;
  logic [3:0] beats;
  logic [3:0] next_beats;
  burst_state_t bstate;
  burst_state_t next_bstate;
  logic b_we;
  logic next_b_we;
  logic [ADDR_W-1:0] wptr;
  logic [ADDR_W-1:0] next_wptr;
  logic [DATA_W+1:0] b_data;
  logic [DATA_W+1:0] next_b_data;
  logic cmd_valid;
  logic is_write;
  logic [3:0] blen;
  logic store;
  logic cmd_short;
  logic [15:0] short_pipe;
  logic [15:0] next_short_pipe;
  logic [3:0] open_idx;
  logic [ADDR_W-1:0] b_addr;
  logic [ADDR_W-1:0] next_b_addr;

  always_comb begin
    // all strobes low-true
    cmd_valid = |(~i_cs_b & b_cs_mask) && !i_cas_b && i_ras_b; // see R10
    is_write = cmd_valid && !i_we_b; // see R10
    unique case (b_burst)
      2'h1: blen = `BURST_FOUR_BEATS; // see R8
      2'h2: blen = !i_bc_b ? `BURST_FOUR_BEATS : `BURST_EIGHT_BEATS; // see R9
      default: blen = `BURST_EIGHT_BEATS; // see R8
    endcase
    cmd_short = (blen == `BURST_FOUR_BEATS); // see R9
    next_wr_pipe = {wr_pipe[14:0], 1'b0};
    next_short_pipe = {short_pipe[14:0], is_write && cmd_short}; // see R9
    if (is_write) begin
      next_wr_pipe[0] = 1'b1;
    end
    next_bstate = bstate;
    next_beats = beats;
    // opens one edge early so the first flagged sample is write latency after the command
    open_idx = b_wl - 4'h2;
    if (wr_pipe[open_idx]) begin // see R2
      next_bstate = st_burst;
      next_beats = short_pipe[open_idx] ? `BURST_FOUR_BEATS : `BURST_EIGHT_BEATS; // see R8 R9
    end else if (bstate == st_burst) begin
      next_beats = beats - 4'h1;
      if (beats <= 4'h1) begin
        next_bstate = st_idle;
      end
    end
    store = b_cke_qual ? (|i_cke) : 1'b1; // see R5 see R6
    next_b_we = store; // see R11
    next_wptr = store ? wptr + 1'b1 : wptr; // see R11
    next_b_data = {bstate == st_burst, cmd_valid, i_dq};
    next_b_addr = wptr; // see R11
    if (!b_rst_b) begin
      next_wr_pipe = '0;
      next_short_pipe = '0;
      next_bstate = st_idle;
      next_beats = 4'h0;
      next_b_we = 1'b0;
      next_wptr = '0;
    end
  end

  always_ff @(posedge i_bus_clk) begin
    wr_pipe <= next_wr_pipe;
    short_pipe <= next_short_pipe;
    b_addr <= next_b_addr;
    beats <= next_beats;
    bstate <= next_bstate;
    b_we <= next_b_we;
    wptr <= next_wptr;
    b_data <= next_b_data;
  end

  // bus-domain assertions
  a_cke_gates_store: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R5
    b_cke_qual && i_cke == 2'h0 |=> !b_we)
    else $error("store while both cke low");
  a_free_run_store: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R6
    !b_cke_qual |=> b_we)
    else $error("edge not stored in unqualified mode");
  a_ptr_holds: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R11
    !b_we && $past(b_rst_b) |-> wptr == $past(wptr))
    else $error("pointer moved without store");
  a_wl5_window: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R2
    is_write && b_wl == 4'h5 ##0 $stable(b_wl)[*1] |-> ##5 bstate == st_burst)
    else $error("write window not opened at latency five");
  a_rank_cs_mask: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R1
    b_cs_mask[3:1] == 3'h0 && i_cs_b[0] |-> !cmd_valid)
    else $error("inactive chip select qualified");
  a_burst_len_at_cmd: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R8 R9
    is_write && b_wl == 4'h5 ##0 $stable(b_wl)[*1] |-> ##5
    beats == ($past(cmd_short, 5) ? `BURST_FOUR_BEATS : `BURST_EIGHT_BEATS))
    else $error("burst length not taken at command");
  a_window_closes: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R8
    bstate == st_burst && beats == 4'h1 && !wr_pipe[open_idx] |=> bstate == st_idle)
    else $error("write window outlives its burst");
  a_mem_addr_step: assert property (@(posedge i_bus_clk) disable iff (!b_rst_b) // see R11
    o_mem_we && $past(o_mem_we) |-> o_mem_addr == $past(o_mem_addr) + 1'b1)
    else $error("store address skipped or repeated");

  // outputs back in the reference domain
  logic [ADDR_W-1:0] wptr_gray;
  logic [ADDR_W-1:0] ref_gray;
  logic [ADDR_W-1:0] next_count;
  logic [ADDR_W-1:0] stored_count;
  always_ff @(posedge i_bus_clk) begin
    wptr_gray <= next_wptr ^ (next_wptr >> 1);
  end
  capture_sync #(.WIDTH(ADDR_W)) u_ptr_sync (
    .i_clk(i_ref_clk),
    .i_async(wptr_gray),
    .o_sync(ref_gray)
  );
  always_comb begin
    next_count[ADDR_W-1] = ref_gray[ADDR_W-1];
    for (int k = ADDR_W - 2; k >= 0; k--) begin
      next_count[k] = next_count[k+1] ^ ref_gray[k];
    end
    if (!i_rst_b) begin
      next_count = '0;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    stored_count <= next_count;
    o_rank_active <= rank_cfg;
    o_write_latency <= wl;
    o_cfg_error <= cfg_error;
    o_stored_count <= stored_count;
  end

  // memory port outputs on the bus clock
  always_ff @(posedge i_bus_clk) begin
    o_mem_we <= b_rst_b ? b_we : 1'b0;
    o_mem_addr <= b_addr;
    o_mem_data <= b_data;
  end

  a_reset_default: assert property (@(posedge i_ref_clk) // see R4
    !i_rst_b |=> rank_cfg == single_rank_setting && wl == `LATENCY_FIVE)
    else $error("reset default not single rank latency five");
  a_illegal_combo: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see R3
    i_rank_cfg > 3'h4 |=> cfg_error && rank_cfg == $past(rank_cfg))
    else $error("illegal rank latency accepted");
  a_two_card_qual: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // see R7
    i_two_card && i_rank_cfg inside {3'h1, 3'h2, 3'h4} |=> !cke_qual)
    else $error("cke qualification with multi rank on two-card");
endmodule

// ===== inc/capture_qualifier_pkg.sv
package capture_qualifier_pkg;
  typedef enum logic [2:0] {
    single_rank_setting = 3'h0,
    dual_rank_setting = 3'h1,
    quad_rank_setting = 3'h2,
    single_rank_wl6 = 3'h3,
    quad_rank_write_latency_twelve = 3'h4
  } rank_cfg_t;
  typedef enum logic [1:0] {
    burst_of_eight = 2'h0,
    burst_of_four = 2'h1,
    burst_dynamic = 2'h2
  } burst_cfg_t;
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_burst = 2'h2
  } burst_state_t;
endpackage

// ===== inc/capture_qualifier_regs.svh
`ifndef CAPTURE_QUALIFIER_REGS_SVH
`define CAPTURE_QUALIFIER_REGS_SVH
`define BURST_EIGHT_BEATS 4'h8
`define BURST_FOUR_BEATS 4'h4
`define LATENCY_FIVE 4'h5
`define LATENCY_SIX 4'h6
`define LATENCY_TWELVE 4'hc
`define RANK_CFG_RESET 3'h0
`endif

// ===== testbench/ddr_bus_model.sv
`timescale 1ns/1ps
module ddr_bus_model (
  input wire logic [1:0] i_cke_sel,
  input wire logic i_cmd,
  output logic o_bus_clk,
  output logic [3:0] o_cs_b,
  output logic [1:0] o_cke,
  output logic o_ras_b,
  output logic o_cas_b,
  output logic o_we_b,
  output logic o_bc_b,
  output logic [71:0] o_dq
);
  logic [31:0] s = 32'h9c3aaee4;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  initial begin
    o_bus_clk = 1'b0;
    o_cs_b = 4'hf;
    o_cke = 2'h0;
    {o_ras_b, o_cas_b, o_we_b, o_bc_b} = 4'hf;
    o_dq = '0;
    #3.3;
    forever #15 o_bus_clk = ~o_bus_clk;
  end
  // quiet, random or held clock enables; a write command on a random chip select
  always @(negedge o_bus_clk) begin
    s = xs(s);
    o_cke <= (i_cke_sel[1] || i_cmd) ? 2'h3 : (i_cke_sel[0] ? s[1:0] : 2'h0);
    o_dq <= {s, ~s, s[7:0]};
    o_bc_b <= s[5];
    o_cs_b <= i_cmd ? ~(4'h1 << s[9:8]) : 4'hf;
    o_ras_b <= 1'b1;
    o_cas_b <= ~i_cmd;
    o_we_b <= ~i_cmd;
  end
endmodule

// ===== testbench/tb_ddr3_capture_qualifier.sv
`timescale 1ns/1ps
module tb_ddr3_capture_qualifier;
  import capture_qualifier_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] rank = 3'h0;
  logic cke_mode = 1'b1;
  logic two_card = 1'b0;
  logic [1:0] burst = 2'h0;
  logic [1:0] sel = 2'h0;
  logic cmd = 1'b0;
  logic run = 1'b0;
  logic bclk, ras_b, cas_b, we_b, bc_b, mem_we, cfg_err;
  logic [3:0] cs_b, wlat;
  logic [1:0] cke;
  logic [71:0] dq;
  logic [11:0] addr, cnt;
  logic [11:0] ptr = 12'h0;
  logic [73:0] data;
  logic [2:0] ract;
  logic [75:0] h [3] = '{default: '0};
  int failures = 0, tests_run = 0, cyc = 0, c = 0, cc = -100, wl = 5, bl = 8;
  always #5 i_ref_clk = ~i_ref_clk;
  ddr_bus_model ddr_bus_model_inst (.i_cke_sel(sel), .i_cmd(cmd), .o_bus_clk(bclk),
    .o_cs_b(cs_b), .o_cke(cke), .o_ras_b(ras_b), .o_cas_b(cas_b), .o_we_b(we_b),
    .o_bc_b(bc_b), .o_dq(dq));
  ddr3_capture_qualifier ddr3_capture_qualifier_inst (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_rank_cfg(rank), .i_cke_mode(cke_mode), .i_two_card(two_card),
    .i_burst_cfg(burst), .i_bus_clk(bclk), .i_cs_b(cs_b), .i_cke(cke), .i_ras_b(ras_b),
    .i_cas_b(cas_b), .i_we_b(we_b), .i_bc_b(bc_b), .i_dq(dq), .o_mem_we(mem_we),
    .o_mem_addr(addr), .o_mem_data(data), .o_rank_active(ract), .o_write_latency(wlat),
    .o_cfg_error(cfg_err), .o_stored_count(cnt));
  task automatic check(input string n, input logic [73:0] s, input logic [73:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [3:0] lat(input logic [2:0] r);
    return (r == 3'h3) ? 4'h6 : ((r == 3'h4) ? 4'hc : 4'h5);
  endfunction
  function automatic logic [3:0] mask(input logic [2:0] r);
    return (r == 3'h0 || r == 3'h3) ? 4'h1 : ((r == 3'h1) ? 4'h3 : 4'hf);
  endfunction
  // each sample shows at the outputs two falling bus edges after it is driven
  always @(negedge bclk) begin
    #1;
    if (run && (~cs_b & mask(rank)) != 4'h0 && ras_b && !cas_b && !we_b) begin
      cc = c;
      wl = lat(rank);
      bl = (burst == 2'h1 || (burst == 2'h2 && !two_card && !bc_b)) ? 4 : 8;
    end
    h[2] = h[1];
    h[1] = h[0];
    h[0] = {run, !cke_mode || (two_card && mask(rank) != 4'h1) || cke != 2'h0,
      c >= cc + wl && c < cc + wl + bl,
      (~cs_b & mask(rank)) != 4'h0 && ras_b && !cas_b, dq};
    c++;
    if (h[2][75]) begin
      check("mem_we", mem_we, h[2][74]);
      if (h[2][74]) begin
        check("addr", addr, ptr);
        check("data", data, h[2][73:0]);
        ptr++;
      end
    end
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    repeat (20) @(negedge i_ref_clk);
    check("rank", ract, 3'h0);
    check("wlat", wlat, 4'h5);
    check("count", cnt, 12'h0);
    i_rst_b = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    run = 1'b1;
    for (int i = 0; i < 10; i++) begin
      sel = 2'h2;
      rank = 3'(i % 5);
      burst = 2'(i % 4);
      cke_mode = (i < 5);
      two_card = (i == 2) || (i == 3);
      repeat (30) @(negedge i_ref_clk);
      check("rank", ract, rank);
      check("wlat", wlat, lat(rank));
      check("err", cfg_err, 1'b0);
      sel = 2'h1;
      repeat (3) begin
        @(posedge bclk) cmd <= 1'b1;
        @(posedge bclk) cmd <= 1'b0;
        repeat (75) @(negedge i_ref_clk);
      end
      $display("test phase %0d done", i);
    end
    sel = 2'h2;
    rank = 3'h5;
    repeat (30) @(negedge i_ref_clk);
    check("err", cfg_err, 1'b1);
    check("wlat", wlat, 4'hc);
    check("rank", ract, 3'h4);
    rank = 3'h0;
    two_card = 1'b0;
    cke_mode = 1'b1;
    repeat (30) @(negedge i_ref_clk);
    sel = 2'h0;
    repeat (60) @(negedge i_ref_clk);
    check("count", cnt, ptr);
    $display("test quiet count done");
    complete_run;
  end
endmodule
